// file: core/timer_pkg.sv
// Constants shared by the three channel compare timer.
package timer_pkg;
  localparam int NCH  = 3;
  localparam int NPIN = 2 * NCH;
  localparam int AW   = 24;
  localparam int DW   = 16;
  localparam int BW   = 8;
  localparam int CW   = 16;
  // Shared registers.
  localparam logic [AW-1:0] ADDR_START  = 24'hFFFEB0;
  localparam logic [AW-1:0] ADDR_SYNC   = 24'hFFFEB1;
  localparam logic [AW-1:0] ADDR_STATUS = 24'hFFFEB2;
  localparam logic [AW-1:0] ADDR_MASK   = 24'hFFFEB4;
  // Per channel registers, channel 0 in the low slot.
  localparam logic [NCH-1:0][AW-1:0] ADDR_COUNT =
    {24'hFFFF36, 24'hFFFF20, 24'hFFFF16};
  localparam logic [NCH-1:0][AW-1:0] ADDR_GEN_A =
    {24'hFFFF38, 24'hFFFF28, 24'hFFFF18};
  localparam logic [NCH-1:0][AW-1:0] ADDR_GEN_B =
    {24'hFFFF3A, 24'hFFFF2A, 24'hFFFF1A};
  localparam logic [NCH-1:0][AW-1:0] ADDR_OUTCTL =
    {24'hFFFF32, 24'hFFFF22, 24'hFFFF12};
  localparam logic [NCH-1:0][AW-1:0] ADDR_MODE =
    {24'hFFFF31, 24'hFFFF21, 24'hFFFF11};
  localparam logic [NCH-1:0][AW-1:0] ADDR_CTL =
    {24'hFFFF30, 24'hFFFF24, 24'hFFFF10};
  // Reset values.
  localparam logic [CW-1:0] CNT_RESET  = 16'h0000;
  localparam logic [CW-1:0] GEN_RESET  = 16'hFFFF;
  localparam logic [BW-1:0] BYTE_RESET = 8'h00;
  // Pin action field layout inside an output control register.
  localparam int FLD_W       = 4;
  localparam int FLD_POS_A   = 0;
  localparam int FLD_POS_B   = 4;
  localparam int FLD_CAPTURE = 3;
  localparam int FLD_INIT    = 2;
  localparam logic [1:0] ACT_OFF  = 2'h0;
  localparam logic [1:0] ACT_LOW  = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOG  = 2'h3;
  // Operating mode field.
  localparam int MODE_W = 4;
  localparam logic [MODE_W-1:0] MODE_PWM2 = 4'h3;
  // Clock control layout and codes.
  localparam int CTL_PSC_POS  = 0;
  localparam int CTL_EDGE_POS = 3;
  localparam int CTL_CLR_POS  = 5;
  localparam logic [2:0] PSC_DIV1  = 3'h0;
  localparam logic [2:0] PSC_DIV4  = 3'h1;
  localparam logic [2:0] PSC_DIV16 = 3'h2;
  localparam int PSC_W     = 6;
  localparam int TAP_DIV4  = 1;
  localparam int TAP_DIV16 = 3;
  localparam int TAP_DIV64 = 5;
  localparam int EDGE_FALL_BIT = 0;
  localparam int EDGE_BOTH_BIT = 1;
  localparam logic [2:0] CLR_GEN_A = 3'h1;
  localparam logic [2:0] CLR_GEN_B = 3'h2;
endpackage

// file: core/three_channel_compare_timer.sv
// Three channel 16-bit timer with compare outputs and capture inputs.
//
// Overview of operation
// - Field B code 0010 starts the B pin low and drives it high on B match.
// - Field A code 0010 starts the A pin low and drives it high on A match.
// - Output control keeps the B field in bits 7 to 4 and A in bits 3 to 0.
// - Each counter is 16 bits and software may read or overwrite it anytime.
// - General registers are 16-bit and act as compare or capture registers.
// - A channel whose run bit is 0 does not count; loads and clears still act on it.
// - A run bit of 1 counts on the chosen clock; run bits sit in bits 2 to 0.
// - A channel with lockstep bit 0 counts on its own.
// - Lockstep channels are loaded and cleared together.
// - Mode code 0011 selects the second pulse width mode.
// - Action code 0000 turns the compare pin off.
// - Prescale code 000 counts on every cycle of the undivided clock.
// - Edge select 00 counts rising, 01 falling, 1X both edges.

`timescale 1ns/1ns
`default_nettype none

module three_channel_compare_timer
(
  // Clock and reset.
  input  wire logic                         sys_clk_in,
  input  wire logic                         resetn_in,
  // Register port.
  input  wire logic [timer_pkg::AW-1:0]     addr_in,
  input  wire logic [timer_pkg::DW-1:0]     wdata_in,
  input  wire logic                         wr_in,
  input  wire logic                         rd_in,
  output logic      [timer_pkg::DW-1:0]     rdata_out,
  // Timer pins, index 2*channel for A and 2*channel+1 for B.
  input  wire logic [timer_pkg::NPIN-1:0]   tio_in,
  output logic      [timer_pkg::NPIN-1:0]   tio_out,
  output logic      [timer_pkg::NPIN-1:0]   tio_oe_out,
  // Interrupt.
  output logic                              irq_out
);

  localparam int NCH  = timer_pkg::NCH;
  localparam int NPIN = timer_pkg::NPIN;
  localparam int CW   = timer_pkg::CW;
  localparam int DW   = timer_pkg::DW;
  localparam int BW   = timer_pkg::BW;

  // Local copies of the package sizes keep the declarations short.
  // They are not parameters: the register map is fixed at three channels.
  // Changing them means changing the address tables as well.

  // Shared state.
  logic [NCH-1:0]             run_q;
  logic [NCH-1:0]             lock_q;
  logic [NPIN-1:0]            stat_q;
  logic [NPIN-1:0]            stat_d;
  logic [NPIN-1:0]            mask_q;
  logic                       irq_q;
  logic [DW-1:0]              rdata_q;
  logic [DW-1:0]              rdata_d;
  logic [timer_pkg::PSC_W-1:0] psc_q;
  logic [timer_pkg::PSC_W-1:0] psc_prev_q;

  // Per channel and per pin state.
  logic [CW-1:0]              count_q  [NCH];
  logic [CW-1:0]              gen_q    [NPIN];
  logic [BW-1:0]              outctl_q [NCH];
  logic [timer_pkg::MODE_W-1:0] mode_q [NCH];
  logic [BW-1:0]              ctl_q    [NCH];
  logic [NPIN-1:0]            pin_q;
  logic [NPIN-1:0]            oe_q;
  logic [NPIN-1:0]            eq_q;
  logic [NPIN-1:0]            sync1_q;
  logic [NPIN-1:0]            sync2_q;
  logic [NPIN-1:0]            sync3_q;

  // The pin state is kept per pin so that A and B of one channel act apart.
  // Event and cross-channel wires.
  wire logic [NPIN-1:0]       evt;
  wire logic [NCH-1:0]        cnt_hit;
  wire logic [NCH-1:0]        clr_req;
  wire logic [NCH-1:0]        ch_load;
  wire logic [NCH-1:0]        ch_clear;
  wire logic                  sync_load;
  wire logic                  sync_clear;

  // Addresses are compared in full, so aliases never hit a register.
  // A write to an unmapped address therefore changes nothing.
  // Shared register write decode.
  wire logic wr_start  = wr_in && (addr_in == timer_pkg::ADDR_START);
  wire logic wr_sync   = wr_in && (addr_in == timer_pkg::ADDR_SYNC);
  wire logic wr_status = wr_in && (addr_in == timer_pkg::ADDR_STATUS);
  wire logic wr_mask   = wr_in && (addr_in == timer_pkg::ADDR_MASK);

  // A write or clear seen by any lockstep channel reaches all of them.
  assign sync_load  = |(cnt_hit & lock_q);
  assign sync_clear = |(clr_req & lock_q);
  assign ch_load    = cnt_hit | (lock_q & {NCH{sync_load}});
  assign ch_clear   = clr_req | (lock_q & {NCH{sync_clear}});

  // Status bits: a new event wins over a write-one clear in the same cycle.
  wire logic [NPIN-1:0] stat_clr = wr_status ? wdata_in[NPIN-1:0]
                                             : {NPIN{1'b0}};
  assign stat_d = (stat_q & ~stat_clr) | evt;

  // Start, lockstep and interrupt registers.
  always_ff @(posedge sys_clk_in)
  begin
    if (!resetn_in)
    begin
      run_q  <= {NCH{1'b0}};
      lock_q <= {NCH{1'b0}};
      stat_q <= {NPIN{1'b0}};
      mask_q <= {NPIN{1'b0}};
      irq_q  <= 1'b0;
    end
    else
    begin
      // Only the run bits are stored, so reserved bits read as zero.
      if (wr_start)
        run_q <= wdata_in[NCH-1:0];
      if (wr_sync)
        lock_q <= wdata_in[NCH-1:0];
      if (wr_mask)
        mask_q <= wdata_in[NPIN-1:0];
      stat_q <= stat_d;
      irq_q  <= |(stat_q & mask_q);
    end
  end

  // The prescaler never stops, so a channel started late sees its first
  // divided edge anywhere within one divided period; software that needs
  // a fixed phase must start the channels together.
  // Free running prescaler shared by all channels.
  always_ff @(posedge sys_clk_in)
  begin
    if (!resetn_in)
    begin
      psc_q      <= {timer_pkg::PSC_W{1'b0}};
      psc_prev_q <= {timer_pkg::PSC_W{1'b0}};
    end
    else
    begin
      psc_q      <= psc_q + 1'b1;
      psc_prev_q <= psc_q;
    end
  end

  // Capture inputs are asynchronous to the system clock.
  // Edges are only looked for after the second stage has settled,
  // so a capture lands about three cycles after the pin moves.
  // Pin inputs pass two flip-flops; the third stage feeds edge detection.
  always_ff @(posedge sys_clk_in)
  begin
    if (!resetn_in)
    begin
      sync1_q <= {NPIN{1'b0}};
      sync2_q <= {NPIN{1'b0}};
      sync3_q <= {NPIN{1'b0}};
    end
    else
    begin
      sync1_q <= tio_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    wire logic [2:0] psel =
      ctl_q[c][timer_pkg::CTL_PSC_POS +: 3];
    wire logic [1:0] esel =
      ctl_q[c][timer_pkg::CTL_EDGE_POS +: 2];
    wire logic [2:0] csel =
      ctl_q[c][timer_pkg::CTL_CLR_POS +: 3];
    wire logic pwm2 = (mode_q[c] == timer_pkg::MODE_PWM2);

    // Edges of the divided clock are found by comparing the prescaler
    // with its copy from the previous cycle, which keeps every counter
    // on the single system clock instead of a derived one.
    // Divided clock level now and one cycle ago.
    wire logic div_now =
      (psel == timer_pkg::PSC_DIV4)  ? psc_q[timer_pkg::TAP_DIV4]  :
      (psel == timer_pkg::PSC_DIV16) ? psc_q[timer_pkg::TAP_DIV16] :
                                       psc_q[timer_pkg::TAP_DIV64];
    wire logic div_old =
      (psel == timer_pkg::PSC_DIV4)  ? psc_prev_q[timer_pkg::TAP_DIV4]  :
      (psel == timer_pkg::PSC_DIV16) ? psc_prev_q[timer_pkg::TAP_DIV16] :
                                       psc_prev_q[timer_pkg::TAP_DIV64];
    wire logic div_rise = div_now & ~div_old;
    wire logic div_fall = ~div_now & div_old;
    wire logic edge_hit =
      esel[timer_pkg::EDGE_BOTH_BIT] ? (div_rise | div_fall) :
      esel[timer_pkg::EDGE_FALL_BIT] ? div_fall : div_rise;
    wire logic tick = run_q[c] &&
      ((psel == timer_pkg::PSC_DIV1) || edge_hit);

    // Register write decode for this channel.
    wire logic wr_outctl =
      wr_in && (addr_in == timer_pkg::ADDR_OUTCTL[c]);
    wire logic wr_mode = wr_in && (addr_in == timer_pkg::ADDR_MODE[c]);
    wire logic wr_ctl  = wr_in && (addr_in == timer_pkg::ADDR_CTL[c]);
    assign cnt_hit[c] = wr_in && (addr_in == timer_pkg::ADDR_COUNT[c]);

    // Counter clear on its own A or B event.
    assign clr_req[c] =
      ((csel == timer_pkg::CLR_GEN_A) && evt[2*c]) ||
      ((csel == timer_pkg::CLR_GEN_B) && evt[2*c+1]);

    // A clear acts even while the channel is stopped, so a match
    // reached on the last count still wraps the counter to zero.
    // Software writes win so that a reload is never lost.
    // Counter: a load beats a clear, which beats a count.
    always_ff @(posedge sys_clk_in)
    begin
      if (!resetn_in)
        count_q[c] <= timer_pkg::CNT_RESET;
      else if (ch_load[c])
        count_q[c] <= wdata_in;
      else if (ch_clear[c])
        count_q[c] <= timer_pkg::CNT_RESET;
      else if (tick)
        count_q[c] <= count_q[c] + 1'b1;
    end

    // Channel control registers.
    always_ff @(posedge sys_clk_in)
    begin
      if (!resetn_in)
      begin
        outctl_q[c] <= timer_pkg::BYTE_RESET;
        mode_q[c]   <= {timer_pkg::MODE_W{1'b0}};
        ctl_q[c]    <= timer_pkg::BYTE_RESET;
      end
      else
      begin
        if (wr_outctl)
          outctl_q[c] <= wdata_in[BW-1:0];
        if (wr_mode)
          mode_q[c] <= wdata_in[timer_pkg::MODE_W-1:0];
        if (wr_ctl)
          ctl_q[c] <= wdata_in[BW-1:0];
      end
    end

    for (genvar r = 0; r < 2; r++)
    begin : g_reg
      localparam int P   = 2 * c + r;
      localparam int POS = (r == 0) ? timer_pkg::FLD_POS_A
                                    : timer_pkg::FLD_POS_B;
      localparam logic [timer_pkg::AW-1:0] GADDR =
        (r == 0) ? timer_pkg::ADDR_GEN_A[c] : timer_pkg::ADDR_GEN_B[c];

      // Pin action field of this register and the one being written.
      wire logic [timer_pkg::FLD_W-1:0] fld =
        outctl_q[c][POS +: timer_pkg::FLD_W];
      wire logic [timer_pkg::FLD_W-1:0] fld_new =
        wdata_in[POS +: timer_pkg::FLD_W];
      wire logic capture = fld[timer_pkg::FLD_CAPTURE];
      wire logic [1:0] act = fld[1:0];
      wire logic eq = (count_q[c] == gen_q[P]);
      wire logic match = eq && !eq_q[P] && !capture;
      wire logic in_rise = sync2_q[P] & ~sync3_q[P];
      wire logic in_fall = ~sync2_q[P] & sync3_q[P];
      wire logic cap_edge =
        act[timer_pkg::EDGE_BOTH_BIT] ? (in_rise | in_fall) :
        act[timer_pkg::EDGE_FALL_BIT] ? in_fall : in_rise;
      wire logic cap = capture && cap_edge;
      wire logic wr_gen = wr_in && (addr_in == GADDR);

      assign evt[P] = match || cap;

      // General register: software write, or counter snapshot on capture.
      always_ff @(posedge sys_clk_in)
      begin
        if (!resetn_in)
          gen_q[P] <= timer_pkg::GEN_RESET;
        else if (wr_gen)
          gen_q[P] <= wdata_in;
        else if (cap)
          gen_q[P] <= count_q[c];
      end

      // A stopped counter that sits on the compare value would otherwise
      // raise a fresh event on every cycle.
      // Equality history so a match fires once when it is reached.
      always_ff @(posedge sys_clk_in)
      begin
        if (!resetn_in)
          eq_q[P] <= 1'b0;
        else
          eq_q[P] <= eq;
      end

      // Compare pin: initial level on a field write, action on match.
      always_ff @(posedge sys_clk_in)
      begin
        if (!resetn_in)
        begin
          pin_q[P] <= 1'b0;
          oe_q[P]  <= 1'b0;
        end
        else
        begin
          oe_q[P] <= !capture && (act != timer_pkg::ACT_OFF);
          if (wr_outctl)
            pin_q[P] <= fld_new[timer_pkg::FLD_INIT];
          else if (match)
          begin
            case (act)
              timer_pkg::ACT_LOW:  pin_q[P] <= 1'b0;
              timer_pkg::ACT_HIGH: pin_q[P] <= 1'b1;
              timer_pkg::ACT_TOG:  pin_q[P] <= ~pin_q[P];
              default:             pin_q[P] <= pin_q[P];
            endcase
          end
          else if (pwm2 && ch_clear[c])
            pin_q[P] <= fld[timer_pkg::FLD_INIT];
        end
      end
    end
  end

  // The mux is evaluated every cycle, but its result is only captured
  // when a read strobe is present, so reads have no side effects.
  // Narrow registers are zero-extended to the bus width.
  // Read multiplexer; unmapped addresses read as zero.
  always_comb
  begin
    rdata_d = {DW{1'b0}};
    if (addr_in == timer_pkg::ADDR_START)
      rdata_d = {{(DW-NCH){1'b0}}, run_q};
    else if (addr_in == timer_pkg::ADDR_SYNC)
      rdata_d = {{(DW-NCH){1'b0}}, lock_q};
    else if (addr_in == timer_pkg::ADDR_STATUS)
      rdata_d = {{(DW-NPIN){1'b0}}, stat_q};
    else if (addr_in == timer_pkg::ADDR_MASK)
      rdata_d = {{(DW-NPIN){1'b0}}, mask_q};
    for (int c = 0; c < NCH; c++)
    begin
      if (addr_in == timer_pkg::ADDR_COUNT[c])
        rdata_d = count_q[c];
      else if (addr_in == timer_pkg::ADDR_GEN_A[c])
        rdata_d = gen_q[2*c];
      else if (addr_in == timer_pkg::ADDR_GEN_B[c])
        rdata_d = gen_q[2*c+1];
      else if (addr_in == timer_pkg::ADDR_OUTCTL[c])
        rdata_d = {{(DW-BW){1'b0}}, outctl_q[c]};
      else if (addr_in == timer_pkg::ADDR_MODE[c])
        rdata_d = {{(DW-timer_pkg::MODE_W){1'b0}}, mode_q[c]};
      else if (addr_in == timer_pkg::ADDR_CTL[c])
        rdata_d = {{(DW-BW){1'b0}}, ctl_q[c]};
    end
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge sys_clk_in)
  begin
    if (!resetn_in)
      rdata_q <= {DW{1'b0}};
    else
      rdata_q <= rd_in ? rdata_d : {DW{1'b0}};
  end

  // No logic sits between a register and a port, so pin timing is clean.
  // The output enable trails a field write by one cycle.
  // Outputs come straight from flip-flops.
  assign rdata_out  = rdata_q;
  assign tio_out    = pin_q;
  assign tio_oe_out = oe_q;
  assign irq_out    = irq_q;

endmodule

`default_nettype wire

// file: tb/timer_asserts.sv
// Concurrent checks on the timer's register port, pins and interrupt.
`timescale 1ns/1ns
`default_nettype none
module timer_asserts
(
  // Clock and reset.
  input wire logic        sys_clk_in,
  input wire logic        resetn_in,
  // Register port.
  input wire logic [23:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [15:0] rdata_out,
  // Pins and interrupt.
  input wire logic [5:0]  tio_in,
  input wire logic [5:0]  tio_out,
  input wire logic [5:0]  tio_oe_out,
  input wire logic        irq_out
);
  logic       oc_wr;
  logic [2:0] oc_hist_q;
  logic [5:0] mask_q;
  // A write to channel 1 output control may legally move its pins.
  assign oc_wr = wr_in && addr_in == timer_pkg::ADDR_OUTCTL[1];
  // Remembers recent control writes and the mask software last wrote.
  always_ff @(posedge sys_clk_in)
  begin
    if (!resetn_in)
    begin
      oc_hist_q <= 3'h0;
      mask_q    <= 6'h00;
    end
    else
    begin
      oc_hist_q <= {oc_hist_q[1:0], oc_wr};
      if (wr_in && addr_in == timer_pkg::ADDR_MASK)
      begin
        mask_q <= wdata_in[5:0];
      end
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
    else $error("read data not zero outside a read answer");
  a_unmapped_read: assert property (rd_in && addr_in == 24'h000100 |=> rdata_out == 16'h0000)
    else $error("unmapped read returned data");
  a_start_readback: assert property (wr_in && addr_in == timer_pkg::ADDR_START
    ##1 !wr_in && !rd_in ##1 rd_in && addr_in == timer_pkg::ADDR_START
    |=> rdata_out == ($past(wdata_in, 3) & 16'h0007))
    else $error("start register readback wrong");
  a_oe_disabled: assert property ((oc_wr && wdata_in[3:0] == 4'h0)
    ##1 (!oc_wr)[*2] |-> !tio_oe_out[2])
    else $error("pin still driven with action off");
  a_init_low: assert property ((oc_wr && wdata_in[3:0] == 4'h2)
    ##1 (!oc_wr)[*2] |-> tio_oe_out[2] && !tio_out[2])
    else $error("pin not driven low after set to rise on match");
  a_pin_no_fall: assert property ($fell(tio_out[2]) |-> oc_hist_q != 3'h0)
    else $error("compare pin fell without a control write");
  a_rise_driven: assert property ($rose(tio_out[3]) && !oc_hist_q[0] |-> tio_oe_out[3])
    else $error("compare pin rose while not driven");
  a_irq_masked: assert property (mask_q == 6'h00 && $past(mask_q) == 6'h00 |-> !irq_out)
    else $error("interrupt raised while fully masked");
  // Main scenarios seen.
  c_pin_rise: cover property ($rose(tio_out[2]));
  c_irq_rise: cover property ($rose(irq_out));
  c_start_rb: cover property (wr_in && addr_in == timer_pkg::ADDR_START ##2 rd_in);
endmodule
`default_nettype wire

// file: tb/tb_three_channel_compare_timer.sv
// Self-checking bench for the three channel compare timer.
`timescale 1ns/1ns
`default_nettype none
module tb_three_channel_compare_timer;
  logic        sys_clk_in, resetn_in, wr_in, rd_in, irq_out;
  logic [23:0] addr_in;
  logic [15:0] wdata_in, rdata_out, v, a, b;
  logic [5:0]  tio_in, tio_out, tio_oe_out;
  int          miscompares, num_checks, c;

  three_channel_compare_timer i_three_channel_compare_timer
  (
    .sys_clk_in (sys_clk_in),
    .resetn_in  (resetn_in),
    .addr_in    (addr_in),
    .wdata_in   (wdata_in),
    .wr_in      (wr_in),
    .rd_in      (rd_in),
    .rdata_out  (rdata_out),
    .tio_in     (tio_in),
    .tio_out    (tio_out),
    .tio_oe_out (tio_oe_out),
    .irq_out    (irq_out)
  );

  // Free running 100 MHz clock.
  initial
  begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Compares one value and reports a mismatch.
  task automatic check(input string what, input logic [15:0] got, exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One register write; ends one idle cycle later on a rising edge.
  task automatic wr(input logic [23:0] ad, input logic [15:0] d);
    addr_in <= ad;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask

  // One register read; data are taken in the cycle after the strobe.
  task automatic rd(input logic [23:0] ad, output logic [15:0] d);
    addr_in <= ad;
    rd_in <= 1'b1;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1;
    d = rdata_out;
    @(posedge sys_clk_in);
  endtask

  task automatic rd_chk(input logic [23:0] ad, input logic [15:0] exp);
    logic [15:0] d;
    rd(ad, d);
    check("register read", d, exp);
  endtask

  // Cuts a hang short.
  initial
  begin
    repeat (20000) @(posedge sys_clk_in);
    miscompares++;
    close_out();
  end

  // Main sequence.
  initial
  begin
    void'($urandom(10));
    {resetn_in, wr_in, rd_in} = 3'h0;
    addr_in = 24'h000000;
    wdata_in = 16'h0000;
    tio_in = 6'h00;
    repeat (12) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    @(posedge sys_clk_in);
    for (c = 0; c < 3; c++)
    begin
      rd_chk(timer_pkg::ADDR_COUNT[c], 16'h0000);
      rd_chk(timer_pkg::ADDR_GEN_A[c], 16'hFFFF);
      rd_chk(timer_pkg::ADDR_GEN_B[c], 16'hFFFF);
      rd_chk(timer_pkg::ADDR_OUTCTL[c], 16'h0000);
    end
    rd_chk(24'h000100, 16'h0000);
    // Random values through a randomly chosen channel's counter and registers on each of 12 passes.
    repeat (12)
    begin
      c = $urandom_range(2);
      v = 16'($urandom);
      wr(timer_pkg::ADDR_COUNT[c], v);
      rd_chk(timer_pkg::ADDR_COUNT[c], v);
      wr(timer_pkg::ADDR_GEN_A[c], ~v);
      rd_chk(timer_pkg::ADDR_GEN_A[c], ~v);
      wr(timer_pkg::ADDR_GEN_B[c], v ^ 16'h5A5A);
      rd_chk(timer_pkg::ADDR_GEN_B[c], v ^ 16'h5A5A);
      wr(timer_pkg::ADDR_OUTCTL[c], v);
      rd_chk(timer_pkg::ADDR_OUTCTL[c], {8'h00, v[7:0]});
      wr(timer_pkg::ADDR_OUTCTL[c], 16'h0000);
    end
    v = 16'($urandom_range(7));
    wr(timer_pkg::ADDR_START, v);
    rd_chk(timer_pkg::ADDR_START, v);
    wr(timer_pkg::ADDR_START, 16'h0000);
    // Stopped counter holds, running one steps every cycle.
    wr(timer_pkg::ADDR_COUNT[2], 16'h0100);
    repeat (5) @(posedge sys_clk_in);
    rd_chk(timer_pkg::ADDR_COUNT[2], 16'h0100);
    wr(timer_pkg::ADDR_START, 16'h0004);
    rd(timer_pkg::ADDR_COUNT[2], a);
    repeat (8) @(posedge sys_clk_in);
    rd(timer_pkg::ADDR_COUNT[2], b);
    check("count step", b - a, 16'h000A);
    wr(timer_pkg::ADDR_START, 16'h0000);
    rd(timer_pkg::ADDR_COUNT[2], a);
    repeat (8) @(posedge sys_clk_in);
    rd_chk(timer_pkg::ADDR_COUNT[2], a);
    // Locked channels load together, a free one does not.
    wr(timer_pkg::ADDR_SYNC, 16'h0003);
    v = 16'($urandom);
    wr(timer_pkg::ADDR_COUNT[0], v);
    rd_chk(timer_pkg::ADDR_COUNT[1], v);
    rd_chk(timer_pkg::ADDR_COUNT[2], a);
    wr(timer_pkg::ADDR_SYNC, 16'h0000);
    wr(timer_pkg::ADDR_COUNT[1], ~v);
    rd_chk(timer_pkg::ADDR_COUNT[0], v);
    // Each channel's pins start low and rise on their matches.
    wr(timer_pkg::ADDR_STATUS, 16'h003F);
    for (c = 0; c < 3; c++)
    begin
      v = 16'($urandom_range(20, 2));
      wr(timer_pkg::ADDR_COUNT[c], 16'h0000);
      wr(timer_pkg::ADDR_GEN_A[c], v);
      wr(timer_pkg::ADDR_GEN_B[c], v + 16'h0003);
      wr(timer_pkg::ADDR_OUTCTL[c], 16'h0022);
      repeat (2) @(posedge sys_clk_in);
      #1;
      check("pins low", {12'h000, tio_oe_out[2*c+:2], tio_out[2*c+:2]}, 16'h000C);
      wr(timer_pkg::ADDR_START, 16'(1 << c));
      repeat (30) @(posedge sys_clk_in);
      #1;
      check("pins high", {14'h0000, tio_out[2*c+:2]}, 16'h0003);
      wr(timer_pkg::ADDR_START, 16'h0000);
    end
    rd_chk(timer_pkg::ADDR_STATUS, 16'h003F);
    check("irq masked", {15'h0000, irq_out}, 16'h0000);
    wr(timer_pkg::ADDR_MASK, 16'h0004);
    @(posedge sys_clk_in);
    #1;
    check("irq raised", {15'h0000, irq_out}, 16'h0001);
    wr(timer_pkg::ADDR_STATUS, 16'h0004);
    @(posedge sys_clk_in);
    #1;
    check("irq cleared", {15'h0000, irq_out}, 16'h0000);
    rd_chk(timer_pkg::ADDR_STATUS, 16'h003B);
    // Action off releases only the A pin of channel 1.
    wr(timer_pkg::ADDR_OUTCTL[1], 16'h0020);
    repeat (2) @(posedge sys_clk_in);
    #1;
    check("enables", {14'h0000, tio_oe_out[3:2]}, 16'h0002);
    // Divide by four, rising then both edges, over forty cycles.
    wr(timer_pkg::ADDR_CTL[0], 16'h0001);
    wr(timer_pkg::ADDR_START, 16'h0001);
    rd(timer_pkg::ADDR_COUNT[0], a);
    repeat (38) @(posedge sys_clk_in);
    rd(timer_pkg::ADDR_COUNT[0], b);
    check("div4 rise", b - a, 16'h000A);
    wr(timer_pkg::ADDR_CTL[0], 16'h0011);
    rd(timer_pkg::ADDR_COUNT[0], a);
    repeat (38) @(posedge sys_clk_in);
    rd(timer_pkg::ADDR_COUNT[0], b);
    check("div4 both", b - a, 16'h0014);
    wr(timer_pkg::ADDR_START, 16'h0000);
    // Second pulse mode on channel 2: clear on A, B pin high from 4 to 7.
    wr(timer_pkg::ADDR_MODE[2], 16'h0003);
    wr(timer_pkg::ADDR_CTL[2], 16'h0020);
    wr(timer_pkg::ADDR_COUNT[2], 16'h0000);
    wr(timer_pkg::ADDR_GEN_A[2], 16'h0008);
    wr(timer_pkg::ADDR_GEN_B[2], 16'h0004);
    wr(timer_pkg::ADDR_OUTCTL[2], 16'h0022);
    wr(timer_pkg::ADDR_START, 16'h0004);
    repeat ($urandom_range(40, 20)) @(posedge sys_clk_in);
    wr(timer_pkg::ADDR_START, 16'h0000);
    rd(timer_pkg::ADDR_COUNT[2], b);
    check("pwm2 wrap", 16'(b < 16'h0008), 16'h0001);
    check("pwm2 pin", 16'(tio_out[5]), 16'(b >= 16'h0004 && b <= 16'h0007));
    close_out();
  end
endmodule

bind three_channel_compare_timer timer_asserts i_timer_asserts
(
  .sys_clk_in (sys_clk_in),
  .resetn_in  (resetn_in),
  .addr_in    (addr_in),
  .wdata_in   (wdata_in),
  .wr_in      (wr_in),
  .rd_in      (rd_in),
  .rdata_out  (rdata_out),
  .tio_in     (tio_in),
  .tio_out    (tio_out),
  .tio_oe_out (tio_oe_out),
  .irq_out    (irq_out)
);
`default_nettype wire
